// ### hdl/ulpi_ctrl_pkg.sv
package ulpi_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_FUNC = 6'h04;
  localparam logic [5:0] OFS_FUNC_SET = 6'h05;
  localparam logic [5:0] OFS_FUNC_CLR = 6'h06;
  localparam logic [5:0] OFS_IFC = 6'h07;
  localparam logic [5:0] OFS_IFC_SET = 6'h08;
  localparam logic [5:0] OFS_IFC_CLR = 6'h09;

  // ----------------------------------------------------------------
  // Function-control fields
  // ----------------------------------------------------------------
  localparam int FC_RSVD = 7;
  localparam int FC_LOW_POWER_N = 6;
  localparam int FC_CORE_RESET = 5;
  localparam int FC_ENC_LSB = 3;
  localparam int FC_TERM = 2;
  localparam int FC_SPEED_LSB = 0;
  localparam logic [7:0] FUNC_RESET = 8'h41;
  localparam logic [7:0] FUNC_WMASK = 8'h7f;

  // ----------------------------------------------------------------
  // Interface-control fields
  // ----------------------------------------------------------------
  localparam int IC_PROTECT_DIS = 7;
  localparam int IC_VBUS_UNQ = 6;
  localparam int IC_VBUS_INV = 5;
  localparam int IC_SELF_WAKE = 4;
  localparam int IC_CLK_KEEP_N = 3;
  localparam int IC_UART = 2;
  localparam int IC_SER3 = 1;
  localparam int IC_SER6 = 0;
  localparam logic [7:0] IFC_RESET = 8'h10;
  localparam logic [7:0] IFC_WMASK = 8'hff;

  // ----------------------------------------------------------------
  // Encodings and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] ENC_NORMAL = 2'h0;
  localparam logic [1:0] ENC_RESERVED = 2'h3;
  localparam int CLK_PERIOD_NS = 50;
  localparam int CORE_RST_NS = 1000;
  localparam logic [7:0] CORE_RST_CYC =
    8'((CORE_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_CORE = 2'b01,
    SEQ_GAP = 2'b11,
    SEQ_RXCMD = 2'b10
  } rst_seq_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic low_power_exit;
    logic serial_exit;
    logic uart_exit;
  } phy_evt_s;

  typedef struct packed {
    logic low_power_n;
    logic core_reset;
    logic [1:0] tx_encoding_select;
    logic termination_select;
    logic [1:0] speed_select;
  } func_out_s;

  typedef struct packed {
    logic protect_enable;
    logic vbus_state;
    logic self_wake_signalling;
    logic serial_clk_on;
    logic uart_pins_select;
    logic serial_three_wire_select;
    logic serial_six_wire_select;
  } ifc_out_s;

  // Decode of one register and its aliases: {clear, set, base}
  function automatic logic [2:0] sel3(input logic [5:0] addr,
                                      input logic [5:0] base);
    sel3 = {addr == base + 6'h02, addr == base + 6'h01, addr == base};
  endfunction : sel3

endpackage : ulpi_ctrl_pkg

// ### hdl/ctrl_reg8.sv
`timescale 1ns/10ps
`default_nettype none

module ctrl_reg8 #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WMASK = 8'hff
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Software write
  input wire logic [2:0] wsel,
  input wire logic [7:0] wdata,
  // Hardware updates
  input wire logic [7:0] hw_set,
  input wire logic [7:0] hw_clr,
  // Contents
  output logic [7:0] q
);

  logic [7:0] q_d;
  logic [7:0] q_q;
  logic [7:0] sw;

  always_comb begin
    sw = q_q;
    if (wsel[0]) begin
      sw = (q_q & ~WMASK) | (wdata & WMASK);
    end else if (wsel[1]) begin
      sw = q_q | (wdata & WMASK);
    end else if (wsel[2]) begin
      sw = q_q & ~(wdata & WMASK);
    end
    q_d = ((sw & ~hw_clr) | hw_set) & WMASK;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q_q <= RESET_VAL;
    end else if (ce) begin
      q_q <= q_d;
    end
  end

  assign q = q_q;

endmodule : ctrl_reg8

`default_nettype wire

// ### hdl/phy_reset_seq.sv
`timescale 1ns/10ps
`default_nettype none

module phy_reset_seq (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Request from the reset bit
  input wire logic start,
  // Sequence outputs
  output logic dir,
  output logic core_reset,
  output logic clr_bit,
  output logic rxcmd_update
);

  ulpi_ctrl_pkg::rst_seq_e st_d;
  ulpi_ctrl_pkg::rst_seq_e st_q;
  logic [7:0] cnt_d;
  logic [7:0] cnt_q;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    unique case (st_q)
      ulpi_ctrl_pkg::SEQ_IDLE: begin
        if (start) begin
          st_d = ulpi_ctrl_pkg::SEQ_CORE;
          cnt_d = ulpi_ctrl_pkg::CORE_RST_CYC - 8'h01;
        end
      end
      ulpi_ctrl_pkg::SEQ_CORE: begin
        if (cnt_q == 8'h00) begin
          st_d = ulpi_ctrl_pkg::SEQ_GAP;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      ulpi_ctrl_pkg::SEQ_GAP: begin
        st_d = ulpi_ctrl_pkg::SEQ_RXCMD;
      end
      ulpi_ctrl_pkg::SEQ_RXCMD: begin
        st_d = ulpi_ctrl_pkg::SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= ulpi_ctrl_pkg::SEQ_IDLE;
      cnt_q <= 8'h00;
    end else if (ce) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // DIR high during core reset, low for one cycle, high for the update
  assign dir = (st_q == ulpi_ctrl_pkg::SEQ_CORE) ||
               (st_q == ulpi_ctrl_pkg::SEQ_RXCMD);
  assign core_reset = (st_q == ulpi_ctrl_pkg::SEQ_CORE);
  assign clr_bit = (st_q == ulpi_ctrl_pkg::SEQ_GAP);
  assign rxcmd_update = (st_q == ulpi_ctrl_pkg::SEQ_RXCMD);

endmodule : phy_reset_seq

`default_nettype wire

// ### hdl/ulpi_phy_func_ifc_ctrl_regs.sv
`timescale 1ns/10ps
`default_nettype none

module ulpi_phy_func_ifc_ctrl_regs (
  // Clock, reset and enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Register access from the link
  input wire ulpi_ctrl_pkg::reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  // Events from the transceiver
  input wire ulpi_ctrl_pkg::phy_evt_s phy_evt,
  // VBUS sensing
  input wire logic ext_bus_power_flag,
  input wire logic vbus_valid_cmp,
  // Transceiver control
  output ulpi_ctrl_pkg::func_out_s func_out,
  output ulpi_ctrl_pkg::ifc_out_s ifc_out,
  // Link handshake
  output logic dir,
  output logic rxcmd_update
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [2:0] func_sel;
  logic [2:0] ifc_sel;
  logic [2:0] func_rd;
  logic [2:0] ifc_rd;

  always_comb begin
    func_rd = ulpi_ctrl_pkg::sel3(reg_req.addr, ulpi_ctrl_pkg::OFS_FUNC);
    ifc_rd = ulpi_ctrl_pkg::sel3(reg_req.addr, ulpi_ctrl_pkg::OFS_IFC);
    func_sel = func_rd & {3{reg_req.wr}};
    ifc_sel = ifc_rd & {3{reg_req.wr}};
  end

  // ----------------------------------------------------------------
  // Function control
  // ----------------------------------------------------------------
  logic [7:0] func_q;
  logic [7:0] func_hw_set;
  logic [7:0] func_hw_clr;
  logic seq_clr;
  logic seq_core_reset;

  always_comb begin
    func_hw_set = 8'h00;
    func_hw_clr = 8'h00;
    func_hw_set[ulpi_ctrl_pkg::FC_LOW_POWER_N] =
      phy_evt.low_power_exit;
    func_hw_clr[ulpi_ctrl_pkg::FC_CORE_RESET] = seq_clr;
  end

  ctrl_reg8 #(
    .RESET_VAL(ulpi_ctrl_pkg::FUNC_RESET),
    .WMASK(ulpi_ctrl_pkg::FUNC_WMASK)
  ) u_func (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .wsel(func_sel),
    .wdata(reg_req.wdata),
    .hw_set(func_hw_set),
    .hw_clr(func_hw_clr),
    .q(func_q)
  );

  // ----------------------------------------------------------------
  // Interface control
  // ----------------------------------------------------------------
  logic [7:0] ifc_q;
  logic [7:0] ifc_hw_clr;

  always_comb begin
    ifc_hw_clr = 8'h00;
    ifc_hw_clr[ulpi_ctrl_pkg::IC_UART] = phy_evt.uart_exit;
    ifc_hw_clr[ulpi_ctrl_pkg::IC_SER3] = phy_evt.serial_exit;
    ifc_hw_clr[ulpi_ctrl_pkg::IC_SER6] = phy_evt.serial_exit;
  end

  ctrl_reg8 #(
    .RESET_VAL(ulpi_ctrl_pkg::IFC_RESET),
    .WMASK(ulpi_ctrl_pkg::IFC_WMASK)
  ) u_ifc (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .wsel(ifc_sel),
    .wdata(reg_req.wdata),
    .hw_set(8'h00),
    .hw_clr(ifc_hw_clr),
    .q(ifc_q)
  );

  // ----------------------------------------------------------------
  // Transceiver reset sequence
  // ----------------------------------------------------------------
  phy_reset_seq u_seq (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .start(func_q[ulpi_ctrl_pkg::FC_CORE_RESET]),
    .dir(dir),
    .core_reset(seq_core_reset),
    .clr_bit(seq_clr),
    .rxcmd_update(rxcmd_update)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;

  always_comb begin
    rdata_d = rdata_q;
    if (reg_req.rd) begin
      if (|func_rd) begin
        rdata_d = func_q;
      end else if (|ifc_rd) begin
        rdata_d = ifc_q;
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (ce) begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Function-control field views
  // ----------------------------------------------------------------
  logic fc_low_power_n;
  logic [1:0] fc_enc;
  logic fc_term;
  logic [1:0] fc_speed;

  always_comb begin
    fc_low_power_n = func_q[ulpi_ctrl_pkg::FC_LOW_POWER_N];
    fc_enc = func_q[ulpi_ctrl_pkg::FC_ENC_LSB +: 2];
    fc_term = func_q[ulpi_ctrl_pkg::FC_TERM];
    fc_speed = func_q[ulpi_ctrl_pkg::FC_SPEED_LSB +: 2];
  end

  // ----------------------------------------------------------------
  // Interface-control field views
  // ----------------------------------------------------------------
  logic ic_protect_dis;
  logic ic_vbus_unq;
  logic ic_vbus_inv;
  logic ic_self_wake;
  logic ic_clk_keep_n;
  logic ic_uart;
  logic ic_ser3;
  logic ic_ser6;

  always_comb begin
    ic_protect_dis = ifc_q[ulpi_ctrl_pkg::IC_PROTECT_DIS];
    ic_vbus_unq = ifc_q[ulpi_ctrl_pkg::IC_VBUS_UNQ];
    ic_vbus_inv = ifc_q[ulpi_ctrl_pkg::IC_VBUS_INV];
    ic_self_wake = ifc_q[ulpi_ctrl_pkg::IC_SELF_WAKE];
    ic_clk_keep_n = ifc_q[ulpi_ctrl_pkg::IC_CLK_KEEP_N];
    ic_uart = ifc_q[ulpi_ctrl_pkg::IC_UART];
    ic_ser3 = ifc_q[ulpi_ctrl_pkg::IC_SER3];
    ic_ser6 = ifc_q[ulpi_ctrl_pkg::IC_SER6];
  end

  // ----------------------------------------------------------------
  // VBUS state for receive commands
  // ----------------------------------------------------------------
  logic vbus_flag;
  logic vbus_qualified;
  logic vbus_state;

  always_comb begin
    vbus_flag = ext_bus_power_flag ^ ic_vbus_inv;
    vbus_qualified = vbus_flag & vbus_valid_cmp;
    if (ic_vbus_unq) begin
      vbus_state = vbus_flag;
    end else begin
      vbus_state = vbus_qualified;
    end
  end

  // ----------------------------------------------------------------
  // Serial and UART clock control
  // ----------------------------------------------------------------
  logic alt_mode;
  logic clk_suspend_honoured;
  logic serial_clk_on;

  always_comb begin
    alt_mode = ic_uart | ic_ser3 | ic_ser6;
    // Clock suspend counts only while the low-power bit is one
    clk_suspend_honoured = fc_low_power_n;
    serial_clk_on = 1'b1;
    if (alt_mode) begin
      if (clk_suspend_honoured) begin
        serial_clk_on = ic_clk_keep_n;
      end else begin
        // Low-power mode has the clock stopped anyway
        serial_clk_on = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode outputs
  // ----------------------------------------------------------------
  ulpi_ctrl_pkg::func_out_s fo_d;
  ulpi_ctrl_pkg::func_out_s fo_q;
  ulpi_ctrl_pkg::ifc_out_s io_d;
  ulpi_ctrl_pkg::ifc_out_s io_q;

  always_comb begin
    fo_d.low_power_n = fc_low_power_n;
    fo_d.core_reset = seq_core_reset;
    // Reserved encoding falls back to normal operation
    if (fc_enc == ulpi_ctrl_pkg::ENC_RESERVED) begin
      fo_d.tx_encoding_select = ulpi_ctrl_pkg::ENC_NORMAL;
    end else begin
      fo_d.tx_encoding_select = fc_enc;
    end
    fo_d.termination_select = fc_term;
    fo_d.speed_select = fc_speed;
  end

  always_comb begin
    io_d.protect_enable = ~ic_protect_dis;
    io_d.vbus_state = vbus_state;
    io_d.self_wake_signalling = ic_self_wake;
    io_d.serial_clk_on = serial_clk_on;
    io_d.uart_pins_select = ic_uart;
    io_d.serial_three_wire_select = ic_ser3;
    io_d.serial_six_wire_select = ic_ser6;
  end

  // ----------------------------------------------------------------
  // Function output register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fo_q.low_power_n <= 1'b0;
      fo_q.core_reset <= 1'b0;
      fo_q.tx_encoding_select <= 2'h0;
      fo_q.termination_select <= 1'b0;
      fo_q.speed_select <= 2'h0;
    end else if (ce) begin
      fo_q <= fo_d;
    end
  end

  // ----------------------------------------------------------------
  // Interface output register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      io_q.protect_enable <= 1'b0;
      io_q.vbus_state <= 1'b0;
      io_q.self_wake_signalling <= 1'b0;
      io_q.serial_clk_on <= 1'b0;
      io_q.uart_pins_select <= 1'b0;
      io_q.serial_three_wire_select <= 1'b0;
      io_q.serial_six_wire_select <= 1'b0;
    end else if (ce) begin
      io_q <= io_d;
    end
  end

  assign func_out = fo_q;
  assign ifc_out = io_q;

endmodule : ulpi_phy_func_ifc_ctrl_regs

`default_nettype wire

// ### verification/link_model.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Link side: register accesses, one byte per request
// ----------------------------------------------------------------
module link_model (
  // Clock
  input wire logic mclk,
  // Register access
  output var ulpi_ctrl_pkg::reg_req_s reg_req,
  input wire logic [7:0] reg_rdata
);
  initial reg_req = '0;

  // Request held over one rising edge, then released
  task automatic acc(input logic w, input logic [5:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(negedge mclk);
    reg_req = {w, !w, a, d};
    @(negedge mclk);
    reg_req = {2'b00, ~a, ~d};
    q = reg_rdata;
  endtask : acc
endmodule : link_model

`default_nettype wire

// ### verification/ctrl_regs_props.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Port checks
// ----------------------------------------------------------------
module ctrl_regs_props (
  // Clock, reset and enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Register access and events
  input wire ulpi_ctrl_pkg::reg_req_s reg_req,
  input wire logic [7:0] reg_rdata,
  input wire ulpi_ctrl_pkg::phy_evt_s phy_evt,
  input wire logic ext_bus_power_flag,
  input wire logic vbus_valid_cmp,
  // Outputs
  input wire ulpi_ctrl_pkg::func_out_s func_out,
  input wire ulpi_ctrl_pkg::ifc_out_s ifc_out,
  input wire logic dir,
  input wire logic rxcmd_update
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_protect_bit: assert property (ce && reg_req.wr &&
    reg_req.addr == 6'h07 |-> ##2
    ifc_out.protect_enable == !$past(reg_req.wdata[7], 2))
    else $error("protect enable wrong");
  a_wake_clear: assert property (ce && reg_req.wr &&
    reg_req.addr == 6'h09 && reg_req.wdata[4] |-> ##2
    !ifc_out.self_wake_signalling) else $error("wake not cleared");
  a_uart_set: assert property (ce && reg_req.wr &&
    reg_req.addr == 6'h08 && reg_req.wdata[2] && !phy_evt.uart_exit
    |-> ##2 ifc_out.uart_pins_select) else $error("uart not set");
  a_uart_exit: assert property (ce && phy_evt.uart_exit
    |-> ##2 !ifc_out.uart_pins_select) else $error("uart not cleared");
  a_serial_exit: assert property (ce && phy_evt.serial_exit
    |-> ##2 !ifc_out.serial_three_wire_select &&
    !ifc_out.serial_six_wire_select) else $error("serial not cleared");
  a_rsvd_zero: assert property (ce && reg_req.rd &&
    reg_req.addr inside {[6'h04:6'h06]} |=> !reg_rdata[7])
    else $error("reserved bit read one");
  a_reset_seq: assert property ($rose(dir) && !rxcmd_update |->
    dir[*8] ##12 dir ##1 !dir ##1 (dir && rxcmd_update))
    else $error("reset sequence wrong");
  a_core_follow: assert property (dir && $past(dir) &&
    !rxcmd_update |=> func_out.core_reset) else $error("core reset low");
  a_clk_gate: assert property (!func_out.low_power_n &&
    (ifc_out.uart_pins_select || ifc_out.serial_three_wire_select ||
    ifc_out.serial_six_wire_select) |-> !ifc_out.serial_clk_on)
    else $error("clock kept in low power");

  c_seq: cover property ($rose(dir));
  c_uart: cover property (phy_evt.uart_exit);
  c_ser: cover property (phy_evt.serial_exit);
endmodule : ctrl_regs_props

bind ulpi_phy_func_ifc_ctrl_regs ctrl_regs_props props (.mclk(mclk),
  .rst_n(rst_n), .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .phy_evt(phy_evt), .ext_bus_power_flag(ext_bus_power_flag),
  .vbus_valid_cmp(vbus_valid_cmp), .func_out(func_out),
  .ifc_out(ifc_out), .dir(dir), .rxcmd_update(rxcmd_update));

`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  fails++; $display("ERROR %s exp %h got %h", n, e, g); end end

module tb_top;
  // ----------------------------------------------------------------
  // Signals and clock
  // ----------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic flag = 1'b0;
  logic cmp = 1'b0;
  logic [7:0] rdata;
  logic [7:0] q;
  logic [3:0] v;
  logic dir;
  logic rxcmd_update;
  ulpi_ctrl_pkg::reg_req_s reg_req;
  ulpi_ctrl_pkg::phy_evt_s phy_evt = '0;
  ulpi_ctrl_pkg::func_out_s func_out;
  ulpi_ctrl_pkg::ifc_out_s ifc_out;
  int fails = 0;
  int check_count = 0;
  int n;
  always #25 mclk = ~mclk;

  link_model lnk (.mclk(mclk), .reg_req(reg_req), .reg_rdata(rdata));
  ulpi_phy_func_ifc_ctrl_regs dut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .reg_req(reg_req), .reg_rdata(rdata), .phy_evt(phy_evt),
    .ext_bus_power_flag(flag), .vbus_valid_cmp(cmp),
    .func_out(func_out), .ifc_out(ifc_out), .dir(dir),
    .rxcmd_update(rxcmd_update));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    lnk.acc(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    lnk.acc(1'b0, a, 8'h00, q);
    `CHK("rdata", e, q)
  endtask : rd_chk

  task automatic evt(input logic [2:0] e);
    @(negedge mclk);
    phy_evt = e;
    @(negedge mclk);
    phy_evt = '0;
  endtask : evt

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    for (int a = 4; a < 11; a++) begin
      rd_chk(6'(a), a < 7 ? 8'h41 : a < 10 ? 8'h10 : 8'h00);
    end
    `CHK("func_rst", 7'h41, func_out)
    `CHK("ifc_rst", 7'h58, ifc_out)
    $display("done resets");
    wr(6'h05, 8'h98);
    rd_chk(6'h06, 8'h59);
    `CHK("enc", 2'h0, func_out.tx_encoding_select)
    wr(6'h06, 8'h91);
    rd_chk(6'h05, 8'h48);
    `CHK("enc_spd", 4'h4, {func_out[4:3], func_out[1:0]})
    wr(6'h05, 8'h04);
    rd_chk(6'h04, 8'h4c);
    `CHK("term", 1'b1, func_out.termination_select)
    wr(6'h04, 8'hc8);
    rd_chk(6'h04, 8'h48);
    wr(6'h06, 8'h40);
    rd_chk(6'h04, 8'h08);
    `CHK("lp_n", 1'b0, func_out.low_power_n)
    evt(3'b100);
    rd_chk(6'h04, 8'h48);
    $display("done func");
    wr(6'h05, 8'h20);
    n = 0;
    for (int i = 0; i < 60 && (n == 0 || dir); i++) begin
      @(negedge mclk);
      n += int'(dir);
    end
    `CHK("dir_len", 20, n)
    @(negedge mclk);
    `CHK("rxcmd", 2'b11, {dir, rxcmd_update})
    rd_chk(6'h04, 8'h48);
    $display("done core reset");
    wr(6'h07, 8'h00);
    wr(6'h08, 8'hff);
    rd_chk(6'h09, 8'hff);
    `CHK("ifc_out", 7'h3f, ifc_out)
    wr(6'h09, 8'h08);
    @(negedge mclk);
    `CHK("clk_on", 1'b0, ifc_out.serial_clk_on)
    wr(6'h06, 8'h40);
    wr(6'h08, 8'h08);
    @(negedge mclk);
    `CHK("clk_on", 1'b0, ifc_out.serial_clk_on)
    evt(3'b100);
    @(negedge mclk);
    `CHK("clk_on", 1'b1, ifc_out.serial_clk_on)
    evt(3'b010);
    rd_chk(6'h07, 8'hfc);
    evt(3'b001);
    rd_chk(6'h07, 8'hf8);
    $display("done modes");
    for (int i = 0; i < 16; i++) begin
      v = 4'(i);
      flag = v[0];
      cmp = v[1];
      wr(6'h07, {v[2], v[3], v[2], 5'h10});
      @(negedge mclk);
      `CHK("vbus", {~v[2], (v[0] ^ v[2]) & (v[3] | v[1])},
        {ifc_out.protect_enable, ifc_out.vbus_state})
    end
    $display("done vbus");
    ce = 1'b0;
    wr(6'h09, 8'hff);
    ce = 1'b1;
    rd_chk(6'h07, 8'hf0);
    rst_n = 1'b0;
    @(negedge mclk);
    rst_n = 1'b1;
    rd_chk(6'h07, 8'h10);
    `CHK("ifc_rst2", 7'h78, ifc_out)
    $display("done freeze and reset");
    close_out();
  end

  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    close_out();
  end
endmodule : tb_top

`default_nettype wire
